// ### logic/scd_pkg.sv
// Shared constants and carrier types of the system clock source and distribution block.
package scd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CSEL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DIV = 8'h04;
  localparam logic [ADDR_W-1:0] REG_GATE = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h0c;

  typedef struct packed {
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } scd_bus_req_t;

  ////////////////////////////////////////////////////////////////////////////
  // Clock select register fields.
  localparam int ROOT_LSB = 0;
  localparam int OBS_LSB = 4;
  localparam int LF_SEL_BIT = 8;
  localparam int HFX_EN_BIT = 9;
  localparam int USB_PLL_REF_BIT = 10;
  localparam int SYSTEM_PLL_REF_BIT = 11;

  // Divider register fields; a divide field holds the ratio minus one.
  localparam int DIVF_W = 5;
  localparam int HDIV_LSB = 0;
  localparam int PDIV_LSB = 8;
  localparam int USB_MUX_BIT = 16;
  localparam int DLY_LSB = 20;
  localparam int DLY_W = 2;
  localparam logic [DIVF_W-1:0] RST_HDIV = 5'h0f;
  localparam logic [DIVF_W-1:0] RST_PDIV = 5'h0f;

  // Clock gating register fields; a set bit stops the clock, but the touch bit stops the touch logic clock only in power mode 2.
  localparam int NUM_PERIPH = 7;
  localparam int PERIPH_LSB = 0;
  localparam int ANALOG_GATE_BIT = 7;
  localparam int TOUCH_GATE_BIT = 8;
  localparam int SPI_GATE_BIT = 9;

  // Status register fields.
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_PWR_LSB = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Sources and modes.
  typedef enum logic [1:0] {
    SCD_ROOT_HF_RC = 2'b00,
    SCD_ROOT_HF_XTAL = 2'b01,
    SCD_ROOT_SYSTEM_PLL = 2'b10,
    SCD_ROOT_TEST = 2'b11
  } scd_root_sel_t;

  localparam int SRC_N = 7;
  localparam int SRC_HF_RC = 0;
  localparam int SRC_HF_XTAL = 1;
  localparam int SRC_LF_RC = 2;
  localparam int SRC_LF_XTAL = 3;
  localparam int SRC_SYSTEM_PLL = 4;
  localparam int SRC_USB_PLL = 5;
  localparam int SRC_TEST = 6;

  localparam logic [1:0] PWR_MODE2 = 2'h2;
  localparam int DCC_W = 6;
  localparam int DLY_DEPTH = 4;

  // Gate slots: peripherals, then high-speed SPI, front end, ADC, touch logic, touch ADC.
  localparam int G_SPI = NUM_PERIPH;
  localparam int G_AFE = NUM_PERIPH + 1;
  localparam int G_ADC = NUM_PERIPH + 2;
  localparam int G_TLOG = NUM_PERIPH + 3;
  localparam int G_TADC = NUM_PERIPH + 4;
  localparam int NUM_GATES = NUM_PERIPH + 5;

endpackage : scd_pkg

// ### logic/scd_clk_div.sv
// Glitch-free integer clock divider, 1 to 32, with coordinated release.
`timescale 1ns/10ps
module scd_clk_div
  import scd_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Input clock as a sampled level and its rising edge.
  input wire logic in_lvl_i,
  input wire logic in_rise_i,
  // Control.
  input wire logic [scd_pkg::DIVF_W-1:0] div_i,
  input wire logic load_i,
  input wire logic go_i,
  // Results.
  output logic ready_o,
  output logic clk_o
);
  import scd_pkg::*;

  typedef struct packed {
    logic [DIVF_W-1:0] cnt;
    logic [DIVF_W-1:0] cur;
    logic pend;
    logic hold;
    logic out;
  } scd_div_st_t;

  scd_div_st_t q, d;

  ////////////////////////////////////////////////////////////////////////////
  // A new ratio is taken only at a period end; the output then waits high,
  // which stretches the high phase instead of cutting it short.
  always_comb begin
    d = q;
    if (load_i) begin
      d.pend = 1'b1;
    end
    if (in_rise_i && !q.hold) begin
      if (q.cnt == q.cur) begin
        d.cnt = '0;
        if (q.pend || load_i) begin
          d.hold = 1'b1;
          d.pend = 1'b0;
        end
      end else begin
        d.cnt = q.cnt + 5'h01;
      end
    end
    if (go_i && q.hold) begin
      d.hold = 1'b0;
      d.cur = div_i;
      d.cnt = '0;
    end
    if (d.hold) begin
      d.out = 1'b1;
    end else if (d.cur == '0) begin
      d.out = in_lvl_i;
    end else begin
      d.out = (d.cnt <= (d.cur >> 1));
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= '{cnt: '0, cur: RST_HDIV, pend: 1'b0, hold: 1'b0, out: 1'b0};
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign ready_o = q.hold;
  assign clk_o = q.out;

  // A held divider keeps its output high until released.
  a_hold_high: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    q.hold |-> q.out) else $error("divider output low while holding");

endmodule : scd_clk_div

// ### logic/scd_clk_gate.sv
// Clock gate whose enable changes only while the clock is low.
`timescale 1ns/10ps
module scd_clk_gate (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Clock level in, enable in, gated clock out.
  input wire logic clk_lvl_i,
  input wire logic en_i,
  output logic clk_o
);

  typedef struct packed {
    logic en;
    logic out;
  } scd_gate_st_t;

  scd_gate_st_t q, d;

  ////////////////////////////////////////////////////////////////////////////
  // The enable is sampled only in the low phase, so no high pulse is clipped.
  always_comb begin
    d = q;
    if (!clk_lvl_i) begin
      d.en = en_i;
    end
    d.out = clk_lvl_i & q.en;
  end

  // State register.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= '{en: 1'b1, out: 1'b0};
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign clk_o = q.out;

  a_gate_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $changed(q.en) |-> !$past(clk_lvl_i)) else $error("gate enable moved in high phase");

endmodule : scd_clk_gate

// ### logic/scd_clock_top.sv
// Root and low-frequency clock selection, division, phase delay and gating.
`timescale 1ns/10ps
module scd_clock_top
  import scd_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register port.
  input wire scd_pkg::scd_bus_req_t bus_i,
  output logic [scd_pkg::DATA_W-1:0] rdata_o,
  // Oscillator and PLL outputs, asynchronous to the reference clock.
  input wire logic [scd_pkg::SRC_N-1:0] src_i,
  // Power mode from the power controller.
  input wire logic [1:0] pwr_mode_i,
  // Oscillator and PLL controls.
  output logic hf_xtal_en_o,
  output logic duty_corr_en_o,
  output logic system_pll_ref_o,
  output logic usb_pll_ref_o,
  // Derived clocks.
  output logic hf_xtal_clk_o,
  output logic low_freq_clk_o,
  output logic rtc_clk_o,
  output logic timer_lf_rc_o,
  output logic timer_lf_xtal_o,
  output logic root_clk_o,
  output logic core_clk_o,
  output logic bus_clk_o,
  output logic irq_clk_o,
  output logic periph_clk_o,
  output logic usb_ctrl_clk_o,
  output logic usb_phy_clk_o,
  output logic obs_clk_o,
  output logic [scd_pkg::NUM_GATES-1:0] gated_clk_o
);
  import scd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State of the block.
  typedef struct packed {
    logic [SRC_N-1:0] s1;
    logic [SRC_N-1:0] s2;
    logic [1:0] root_sel;
    logic [3:0] obs_sel;
    logic lf_sel;
    logic hfx_en;
    logic usb_pll_ref;
    logic system_pll_ref;
    logic [DIVF_W-1:0] hdiv;
    logic [DIVF_W-1:0] pdiv;
    logic usb_mux;
    logic [DLY_W-1:0] dly;
    logic [NUM_PERIPH-1:0] periph_off;
    logic analog_off;
    logic touch_off;
    logic spi_off;
    logic [DATA_W-1:0] rdata;
    logic load;
    logic go;
    logic root;
    logic root_prev;
    logic [DLY_DEPTH-1:0] dly_line;
    logic sys_clk;
    logic xtal_prev;
    logic [DCC_W-1:0] dcc_cnt;
    logic [DCC_W-1:0] dcc_per;
    logic dcc_out;
    logic low_freq_clock;
    logic rtc_clk;
    logic lf_rc;
    logic lf_xtal;
    logic usb_phy;
    logic system_pll_ref_clk;
    logic usb_pll_ref_clk;
    logic obs;
  } scd_top_st_t;

  scd_top_st_t q, d;

  logic hclk, pclk, peripheral_unit_clock;
  logic h_rdy, p_rdy, u_rdy;
  logic [DIVF_W-1:0] udiv;
  logic root_rise;
  logic [NUM_GATES-1:0] gate_in, gate_en;

  ////////////////////////////////////////////////////////////////////////////
  // The USB control divider uses the core ratio, or half of it, truncated.
  always_comb begin
    if (!q.usb_mux) begin
      udiv = q.hdiv;
    end else if (q.hdiv == '0) begin
      udiv = '0;
    end else begin
      // Worked one bit wider so that a ratio of 32 does not wrap to zero.
      udiv = DIVF_W'((({1'b0, q.hdiv} + 6'h01) >> 1) - 6'h01);
    end
  end

  assign root_rise = q.root & !q.root_prev;

  // Three parallel root dividers: core, peripheral and USB control.
  scd_clk_div u_hdiv (
    .ref_clk_i (ref_clk_i),
    .rst_i (rst_i),
    .ce_i (ce_i),
    .in_lvl_i (q.root),
    .in_rise_i (root_rise),
    .div_i (q.hdiv),
    .load_i (q.load),
    .go_i (q.go),
    .ready_o (h_rdy),
    .clk_o (hclk)
  );

  scd_clk_div u_pdiv (
    .ref_clk_i (ref_clk_i),
    .rst_i (rst_i),
    .ce_i (ce_i),
    .in_lvl_i (q.root),
    .in_rise_i (root_rise),
    .div_i (q.pdiv),
    .load_i (q.load),
    .go_i (q.go),
    .ready_o (p_rdy),
    .clk_o (pclk)
  );

  scd_clk_div u_udiv (
    .ref_clk_i (ref_clk_i),
    .rst_i (rst_i),
    .ce_i (ce_i),
    .in_lvl_i (q.root),
    .in_rise_i (root_rise),
    .div_i (udiv),
    .load_i (q.load),
    .go_i (q.go),
    .ready_o (u_rdy),
    .clk_o (peripheral_unit_clock)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Gate inputs and enables; analog and touch clocks take the undelayed core
  // clock so that their sampling phase differs from the digital system.
  always_comb begin
    gate_in = '0;
    gate_en = '0;
    gate_in[NUM_PERIPH-1:0] = {NUM_PERIPH{pclk}};
    gate_en[NUM_PERIPH-1:0] = ~q.periph_off;
    gate_in[G_SPI] = q.sys_clk;
    gate_en[G_SPI] = !q.spi_off;
    gate_in[G_AFE] = hclk;
    gate_in[G_ADC] = hclk;
    gate_en[G_AFE] = !q.analog_off;
    gate_en[G_ADC] = !q.analog_off;
    gate_in[G_TLOG] = hclk;
    gate_en[G_TLOG] = !(q.touch_off && (pwr_mode_i == PWR_MODE2));
    gate_in[G_TADC] = hclk;
    gate_en[G_TADC] = !q.touch_off;
  end

  // One gate per gated clock.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GATES; gi++) begin : g_gate
      scd_clk_gate u_gate (
        .ref_clk_i (ref_clk_i),
        .rst_i (rst_i),
        .ce_i (ce_i),
        .clk_lvl_i (gate_in[gi]),
        .en_i (gate_en[gi]),
        .clk_o (gated_clk_o[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: synchronisers, register port, selection and delay.
  always_comb begin
    d = q;
    d.s1 = src_i;
    d.s2 = q.s1;
    d.load = 1'b0;
    d.go = 1'b0;
    d.rdata = '0;

    // Register writes.
    if (bus_i.we) begin
      unique case (bus_i.addr)
        REG_CSEL: begin
          d.root_sel = bus_i.wdata[ROOT_LSB +: 2];
          d.obs_sel = bus_i.wdata[OBS_LSB +: 4];
          d.lf_sel = bus_i.wdata[LF_SEL_BIT];
          d.hfx_en = bus_i.wdata[HFX_EN_BIT];
          d.usb_pll_ref = bus_i.wdata[USB_PLL_REF_BIT];
          d.system_pll_ref = bus_i.wdata[SYSTEM_PLL_REF_BIT];
        end
        REG_DIV: begin
          d.hdiv = bus_i.wdata[HDIV_LSB +: DIVF_W];
          d.pdiv = bus_i.wdata[PDIV_LSB +: DIVF_W];
          d.usb_mux = bus_i.wdata[USB_MUX_BIT];
          d.dly = bus_i.wdata[DLY_LSB +: DLY_W];
          d.load = 1'b1;
        end
        REG_GATE: begin
          d.periph_off = bus_i.wdata[PERIPH_LSB +: NUM_PERIPH];
          d.analog_off = bus_i.wdata[ANALOG_GATE_BIT];
          d.touch_off = bus_i.wdata[TOUCH_GATE_BIT];
          d.spi_off = bus_i.wdata[SPI_GATE_BIT];
        end
        default: begin
        end
      endcase
    end

    // Register reads answer in the next cycle only; unmapped reads give zero.
    if (bus_i.re) begin
      unique case (bus_i.addr)
        REG_CSEL: begin
          d.rdata[ROOT_LSB +: 2] = q.root_sel;
          d.rdata[OBS_LSB +: 4] = q.obs_sel;
          d.rdata[LF_SEL_BIT] = q.lf_sel;
          d.rdata[HFX_EN_BIT] = q.hfx_en;
          d.rdata[USB_PLL_REF_BIT] = q.usb_pll_ref;
          d.rdata[SYSTEM_PLL_REF_BIT] = q.system_pll_ref;
        end
        REG_DIV: begin
          d.rdata[HDIV_LSB +: DIVF_W] = q.hdiv;
          d.rdata[PDIV_LSB +: DIVF_W] = q.pdiv;
          d.rdata[USB_MUX_BIT] = q.usb_mux;
          d.rdata[DLY_LSB +: DLY_W] = q.dly;
        end
        REG_GATE: begin
          d.rdata[PERIPH_LSB +: NUM_PERIPH] = q.periph_off;
          d.rdata[ANALOG_GATE_BIT] = q.analog_off;
          d.rdata[TOUCH_GATE_BIT] = q.touch_off;
          d.rdata[SPI_GATE_BIT] = q.spi_off;
        end
        REG_STAT: begin
          d.rdata[ROOT_LSB +: 2] = q.root_sel;
          d.rdata[STAT_BUSY_BIT] = h_rdy | p_rdy | u_rdy;
          d.rdata[STAT_PWR_LSB +: 2] = pwr_mode_i;
        end
        default: begin
        end
      endcase
    end

    // Release all dividers at once when the last one is ready.
    d.go = h_rdy && p_rdy && u_rdy && !q.go;

    // Root clock selection.
    unique case (scd_root_sel_t'(q.root_sel))
      SCD_ROOT_HF_RC: d.root = q.s2[SRC_HF_RC];
      SCD_ROOT_HF_XTAL: d.root = q.dcc_out;
      SCD_ROOT_SYSTEM_PLL: d.root = q.s2[SRC_SYSTEM_PLL];
      SCD_ROOT_TEST: d.root = q.s2[SRC_TEST];
    endcase
    d.root_prev = q.root;

    // Duty correction: high for half of the last measured crystal period.
    d.xtal_prev = q.s2[SRC_HF_XTAL];
    if (!q.hfx_en) begin
      d.dcc_cnt = '0;
      d.dcc_out = 1'b0;
    end else begin
      if (q.s2[SRC_HF_XTAL] && !q.xtal_prev) begin
        d.dcc_per = q.dcc_cnt;
        d.dcc_cnt = '0;
      end else if (q.dcc_cnt != '1) begin
        d.dcc_cnt = q.dcc_cnt + 6'h01;
      end
      d.dcc_out = (d.dcc_cnt <= (q.dcc_per >> 1));
    end

    // Phase delay of the digital system clock.
    d.dly_line = {q.dly_line[DLY_DEPTH-2:0], hclk};
    d.sys_clk = q.dly_line[q.dly];

    // Low-frequency, real-time, timer, PLL reference and observation clocks.
    d.low_freq_clock = q.lf_sel ? q.s2[SRC_LF_XTAL] : q.s2[SRC_LF_RC];
    d.rtc_clk = q.s2[SRC_LF_XTAL];
    d.lf_rc = q.s2[SRC_LF_RC];
    d.lf_xtal = q.s2[SRC_LF_XTAL];
    d.usb_phy = q.s2[SRC_USB_PLL];
    d.system_pll_ref_clk = q.system_pll_ref ? q.dcc_out : q.s2[SRC_HF_RC];
    d.usb_pll_ref_clk = q.usb_pll_ref ? q.dcc_out : q.s2[SRC_HF_RC];
    unique case (q.obs_sel)
      4'h0: d.obs = q.root;
      4'h1: d.obs = q.low_freq_clock;
      4'h2: d.obs = hclk;
      4'h3: d.obs = q.sys_clk;
      4'h4: d.obs = q.sys_clk;
      4'h5: d.obs = pclk;
      4'h6: d.obs = peripheral_unit_clock;
      4'h7: d.obs = q.usb_phy;
      4'hc: d.obs = q.rtc_clk;
      default: d.obs = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves the RC oscillator divided by sixteen.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.root_sel <= SCD_ROOT_HF_RC;
      q.hdiv <= RST_HDIV;
      q.pdiv <= RST_PDIV;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Outputs.
  assign rdata_o = q.rdata;
  assign hf_xtal_en_o = q.hfx_en;
  assign duty_corr_en_o = q.hfx_en;
  assign system_pll_ref_o = q.system_pll_ref_clk;
  assign usb_pll_ref_o = q.usb_pll_ref_clk;
  assign hf_xtal_clk_o = q.dcc_out;
  assign low_freq_clk_o = q.low_freq_clock;
  assign rtc_clk_o = q.rtc_clk;
  assign timer_lf_rc_o = q.lf_rc;
  assign timer_lf_xtal_o = q.lf_xtal;
  assign root_clk_o = q.root;
  assign core_clk_o = q.sys_clk;
  assign bus_clk_o = q.sys_clk;
  assign irq_clk_o = q.sys_clk;
  assign periph_clk_o = pclk;
  assign usb_ctrl_clk_o = peripheral_unit_clock;
  assign usb_phy_clk_o = q.usb_phy;
  assign obs_clk_o = q.obs;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_reset_slow_core: assert property (@(posedge ref_clk_i)
    $fell(rst_i) |-> (q.hdiv == RST_HDIV) && (q.root_sel == SCD_ROOT_HF_RC))
    else $error("reset divider or source wrong");

  a_root_rc_path: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && q.root_sel == SCD_ROOT_HF_RC && $stable(q.root_sel) && $past(ce_i)
    |=> q.root == $past(q.s2[SRC_HF_RC])) else $error("root not following RC");

  a_root_pll_path: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && q.root_sel == SCD_ROOT_SYSTEM_PLL |=> !ce_i || q.root == $past(q.s2[SRC_SYSTEM_PLL]))
    else $error("root not following PLL");

  a_rtc_from_xtal: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i |=> !ce_i || rtc_clk_o == $past(q.s2[SRC_LF_XTAL]))
    else $error("real-time clock not from crystal");

  a_usb_phy_src: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i ##1 ce_i |-> usb_phy_clk_o == $past(q.s2[SRC_USB_PLL]))
    else $error("phy clock not from USB PLL");

  a_release_together: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    q.go |-> $past(h_rdy && p_rdy && u_rdy)) else $error("early divider release");

  a_release_aligned: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (q.go && ce_i) |=> !h_rdy && !p_rdy && !u_rdy) else $error("dividers left unaligned");

  a_analog_pair: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    q.analog_off && !hclk && ce_i ##1 ce_i |=> !gated_clk_o[G_AFE] && !gated_clk_o[G_ADC])
    else $error("front-end clocks running while stopped");

  a_touch_mode2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    q.touch_off && pwr_mode_i != PWR_MODE2 && !hclk && ce_i ##1 hclk && ce_i
    |=> gated_clk_o[G_TLOG]) else $error("touch logic gated outside power mode 2");

  a_dcc_with_xtal: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !q.hfx_en ##1 ce_i |-> !hf_xtal_clk_o) else $error("corrected crystal runs while off");

  a_read_once: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && !bus_i.re |=> rdata_o == '0) else $error("read data outside its cycle");

endmodule : scd_clock_top

// ### bench/scd_src_model.sv
// Free-running oscillator and PLL levels that feed the clock block.
`timescale 1ns/10ps
module scd_src_model
  import scd_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Source levels.
  output logic [scd_pkg::SRC_N-1:0] src_o
);
  int cnt [SRC_N];

  // Source k toggles every k+1 reference cycles, so each source has its own rate.
  always_ff @(posedge ref_clk_i) begin
    for (int k = 0; k < SRC_N; k++) begin
      if (rst_i || cnt[k] == k) begin
        cnt[k] <= 0;
      end else begin
        cnt[k] <= cnt[k] + 1;
      end
      if (rst_i) begin
        src_o[k] <= 1'b0;
      end else if (cnt[k] == k) begin
        src_o[k] <= ~src_o[k];
      end
    end
  end
endmodule : scd_src_model

// ### bench/tb_top.sv
// Self-checking bench of the clock source and distribution block.
`timescale 1ns/10ps
module tb_top;
  import scd_pkg::*;
  logic ref_clk_i;
  logic rst_i;
  logic ce;
  logic [1:0] pwr_mode_i;
  scd_bus_req_t bus_q;
  logic [DATA_W-1:0] rdata_o;
  logic [SRC_N-1:0] src;
  logic hf_xtal_en_o, duty_corr_en_o, hf_xtal_clk_o, rtc_clk_o, core_clk_o, usb_phy_clk_o;
  logic [NUM_GATES-1:0] gated_clk_o;
  logic [15:0] obs;
  int num_errors;
  int compares;
  int cycles;

  ////////////////////////////////////////////////////////////////////////////
  // Device, sources and the watched clock vector.
  scd_src_model u_scd_src_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .src_o(src));
  scd_clock_top u_scd_clock_top (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .bus_i(bus_q), .rdata_o(rdata_o),
    .src_i(src), .pwr_mode_i(pwr_mode_i), .hf_xtal_en_o(hf_xtal_en_o),
    .duty_corr_en_o(duty_corr_en_o), .system_pll_ref_o(), .usb_pll_ref_o(),
    .hf_xtal_clk_o(hf_xtal_clk_o), .low_freq_clk_o(), .rtc_clk_o(rtc_clk_o),
    .timer_lf_rc_o(), .timer_lf_xtal_o(), .root_clk_o(), .core_clk_o(core_clk_o),
    .bus_clk_o(), .irq_clk_o(), .periph_clk_o(), .usb_ctrl_clk_o(),
    .usb_phy_clk_o(usb_phy_clk_o), .obs_clk_o(), .gated_clk_o(gated_clk_o));
  assign obs = {gated_clk_o, usb_phy_clk_o, rtc_clk_o, hf_xtal_clk_o, core_clk_o};

  // Clock at 40 ns and a cycle ceiling that cuts a hang short.
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    bus_q.we <= 1'b1;
    bus_q.addr <= a;
    bus_q.wdata <= d;
    @(posedge ref_clk_i);
    bus_q.we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    bus_q.re <= 1'b1;
    bus_q.addr <= a;
    @(posedge ref_clk_i);
    bus_q.re <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  // Marks every watched clock that changed level within a 150 cycle window.
  task automatic act(output logic [15:0] m);
    logic [15:0] first;
    repeat (10) @(posedge ref_clk_i);
    #1 first = obs;
    m = '0;
    repeat (150) begin
      @(posedge ref_clk_i);
      #1 m = m | (obs ^ first);
    end
  endtask : act
  task automatic tally_and_finish();
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic s_reset();
    logic [31:0] d;
    rd(REG_DIV, d);
    chk(d, 32'h0000_0f0f);
    rd(REG_CSEL, d);
    chk(d, 32'h0000_0000);
    rd(8'h10, d);
    chk(d, 32'h0000_0000);
  endtask : s_reset
  task automatic s_root();
    logic [31:0] d;
    logic [15:0] m;
    wr(REG_DIV, 32'h0030_0000);
    rd(REG_DIV, d);
    chk(d, 32'h0030_0000);
    // The crystal runs only while enabled, so it is enabled while it feeds the root.
    for (int c = 0; c < 3; c++) begin
      wr(REG_CSEL, c | ((c == 1) ? 32'h200 : 32'h0));
      rd(REG_STAT, d);
      chk(d & 32'h33, c);
      act(m);
      chk(m[3:0], (c == 1) ? 4'hf : 4'hd);
    end
  endtask : s_root
  task automatic s_xtal();
    logic [15:0] m;
    chk({hf_xtal_en_o, duty_corr_en_o}, 2'b00);
    wr(REG_CSEL, 32'h0000_0202);
    act(m);
    chk({hf_xtal_en_o, duty_corr_en_o, m[1]}, 3'b111);
  endtask : s_xtal
  task automatic s_gate();
    logic [31:0] gv [5] = '{32'h8, 32'h80, 32'h100, 32'h100, 32'h200};
    logic [1:0] pm [5] = '{2'h0, 2'h0, 2'h0, PWR_MODE2, 2'h0};
    logic [11:0] ex [5] = '{12'hff7, 12'hcff, 12'h7ff, 12'h3ff, 12'hf7f};
    logic [15:0] m;
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      pwr_mode_i <= pm[i];
      wr(REG_GATE, gv[i]);
      rd(REG_STAT, d);
      chk(d[5:4], pm[i]);
      act(m);
      chk(m[15:4], ex[i]);
      chk(obs[15:4] & ~ex[i], 12'h000);
    end
  endtask : s_gate
  // Clock enable low freezes every clock and ignores the register port.
  task automatic s_freeze();
    logic [31:0] d;
    logic [15:0] m;
    ce <= 1'b0;
    wr(REG_GATE, 32'h0000_03ff);
    act(m);
    chk(m, 16'h0000);
    ce <= 1'b1;
    rd(REG_GATE, d);
    chk(d, 32'h0000_0200);
  endtask : s_freeze

  // Main sequence: reset for 10 cycles, then every scenario.
  initial begin
    num_errors = 0;
    compares = 0;
    cycles = 0;
    rst_i = 1'b1;
    ce = 1'b1;
    pwr_mode_i = 2'h0;
    bus_q = '0;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_root();
    s_xtal();
    s_gate();
    s_freeze();
    tally_and_finish();
  end
endmodule : tb_top
